// *** logic/wake_cdr_config_regs.sv ***
// Purpose : Calibration status and recovery control registers of the wake receiver
// Assumes : Register port strobes are synchronous one-cycle pulses
// Notes   : i_rst_n is power-on or soft reset; i_restart keeps stored settings
`default_nettype none
// Summary of operation
// [RULE1] Calibration word: high byte 15:8, low 7:0
// [RULE2] Calibration cleared by reset, kept on restart
// [RULE3] Control reserved bits always read zero
// [RULE4] Recovery runs only while enable bit set
// [RULE5] Filter select 00/01/10 gives 8/16/32
// [RULE6] Select 11 adapts constant to edge spacing
// [RULE7] Clock select picks 75 down to 9.375 MHz
// [RULE8] Reset loads 0x0004; restart keeps fields
// [RULE9] Host avoids clock settings overflowing quanta counter
// [RULE10] Writes to read-only or reserved bits ignored
module wake_cdr_config_regs
   import cdr_regs_pkg::*;
(
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_restart,
   // Register port
   input  wire logic [6:0]  i_reg_addr,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic [15:0] i_reg_wdata,
   output logic      [15:0] o_reg_rdata,
   output logic             o_reg_rvalid,
   output logic             o_reg_hit,
   // Oscillator calibration result
   input  wire logic        i_cal_load,
   input  wire logic [7:0]  i_cal_high,
   input  wire logic [7:0]  i_cal_low,
   // Recovery unit
   input  wire logic        i_spacing_valid,
   input  wire logic [3:0]  i_spacing,
   output logic             o_recovery_enable,
   output logic      [1:0]  o_recovery_clk_sel,
   output logic      [16:0] o_recovery_clk_khz,
   output logic      [5:0]  o_time_const
);
   logic        rst_meta_q;
   logic        rst_sync_q;
   logic [15:0] cal_q;
   logic [15:0] cal_d;
   logic [15:0] ctrl_q;
   logic [15:0] ctrl_d;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic        rvalid_q;
   logic        rvalid_d;
   logic        hit_cal;
   logic        hit_ctrl;
   logic        rst_n;

   filter_cfg_if cfg ();

   // Reset release through two flip-flops
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_n = rst_sync_q;

   // Address decode
   assign hit_cal   = (i_reg_addr == OSC_CAL_STATUS_ADDR);
   assign hit_ctrl  = (i_reg_addr == RECOVERY_CONTROL_ADDR);
   assign o_reg_hit = hit_cal | hit_ctrl;

   // Calibration word: loaded by hardware only, frozen during restart
   always_comb begin
      cal_d = cal_q;                                        // [RULE10]
      if (i_cal_load && !i_restart) begin
         cal_d[CAL_HIGH_MSB:CAL_HIGH_LSB] = i_cal_high;     // [RULE1]
         cal_d[CAL_LOW_MSB:CAL_LOW_LSB]   = i_cal_low;      // [RULE1]
      end
   end

   // Control word: host writes only the writable fields
   always_comb begin
      ctrl_d = ctrl_q;
      if (i_restart) begin
         ctrl_d = ctrl_q & RECOVERY_CONTROL_MASK;           // [RULE8]
      end else if (i_reg_wr && hit_ctrl) begin
         ctrl_d = i_reg_wdata & RECOVERY_CONTROL_MASK;      // [RULE10]
      end
   end

   // Read data captured one cycle after the read strobe
   always_comb begin
      rvalid_d = i_reg_rd;
      rdata_d  = rdata_q;
      if (i_reg_rd) begin
         if (hit_cal) begin
            rdata_d = cal_q;                                // [RULE1]
         end else if (hit_ctrl) begin
            rdata_d = ctrl_q & RECOVERY_CONTROL_MASK;       // [RULE3]
         end else begin
            rdata_d = 16'h0000;
         end
      end
   end

   // Register state
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         cal_q    <= OSC_CAL_STATUS_RST;                    // [RULE2]
         ctrl_q   <= RECOVERY_CONTROL_RST;                  // [RULE8]
         rdata_q  <= 16'h0000;
         rvalid_q <= 1'b0;
      end else begin
         cal_q    <= cal_d;                                 // [RULE2]
         ctrl_q   <= ctrl_d;
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign o_reg_rdata  = rdata_q;
   assign o_reg_rvalid = rvalid_q;

   // Settings handed to the recovery unit
   assign cfg.enable        = ctrl_q[ENABLE_POS];
   assign cfg.filter_sel    = ctrl_q[FILTER_SEL_MSB:FILTER_SEL_LSB];
   assign cfg.spacing_valid = i_spacing_valid & ctrl_q[ENABLE_POS];
   assign cfg.spacing       = i_spacing;

   time_const_select u_time_const (
      .i_clk   (i_clk),
      .i_rst_n (rst_n),
      .cfg     (cfg)
   );

   // Recovery unit controls; the host keeps clock choice within counter range
   assign o_recovery_enable  = ctrl_q[ENABLE_POS];                               // [RULE4]
   assign o_recovery_clk_sel = ctrl_q[CLK_SEL_MSB:CLK_SEL_LSB];                  // [RULE7]
   assign o_recovery_clk_khz = clk_rate_khz(ctrl_q[CLK_SEL_MSB:CLK_SEL_LSB]);    // [RULE7] [RULE9]
   assign o_time_const       = ctrl_q[ENABLE_POS] ? cfg.time_const : 6'h00;      // [RULE4]
endmodule : wake_cdr_config_regs
`default_nettype wire

// *** logic/cdr_regs_pkg.sv ***
// Purpose : Constants and types shared by the wake receiver recovery register bank
// Assumes : Word-addressed register port with 7-bit addresses and 16-bit data
// Notes   : Offsets are word addresses on the serial register port
`default_nettype none
package cdr_regs_pkg;
   // Register word addresses
   localparam logic [6:0]  OSC_CAL_STATUS_ADDR   = 7'h3D;
   localparam logic [6:0]  RECOVERY_CONTROL_ADDR = 7'h3E;
   // Calibration status field positions
   localparam int          CAL_HIGH_MSB          = 15;
   localparam int          CAL_HIGH_LSB          = 8;
   localparam int          CAL_LOW_MSB           = 7;
   localparam int          CAL_LOW_LSB           = 0;
   // Recovery control field positions
   localparam int          ENABLE_POS            = 0;
   localparam int          FILTER_SEL_LSB        = 2;
   localparam int          FILTER_SEL_MSB        = 3;
   localparam int          CLK_SEL_LSB           = 5;
   localparam int          CLK_SEL_MSB           = 6;
   // Writable bits of the control word: enable, filter and clock selection
   localparam logic [15:0] RECOVERY_CONTROL_MASK = 16'h006D;
   // Reset values after power-on or soft reset
   localparam logic [15:0] OSC_CAL_STATUS_RST    = 16'h0000;
   localparam logic [15:0] RECOVERY_CONTROL_RST  = 16'h0004;
   // Loop filter time constants
   localparam logic [5:0]  TIME_CONST_8          = 6'h08;
   localparam logic [5:0]  TIME_CONST_16         = 6'h10;
   localparam logic [5:0]  TIME_CONST_32         = 6'h20;
   // Adaptive mode falling-edge spacing bounds in bit times
   localparam logic [3:0]  SPACING_SHORT_MIN     = 4'h2;
   localparam logic [3:0]  SPACING_MID_MIN       = 4'h4;
   localparam logic [3:0]  SPACING_LONG_MIN      = 4'h9;
   localparam logic [3:0]  SPACING_LONG_MAX      = 4'hA;
   // Recovery clock rates in kHz
   localparam logic [16:0] CLK_RATE_75000_KHZ    = 17'h124F8;
   localparam logic [16:0] CLK_RATE_37500_KHZ    = 17'h0927C;
   localparam logic [16:0] CLK_RATE_18750_KHZ    = 17'h0493E;
   localparam logic [16:0] CLK_RATE_9375_KHZ     = 17'h0249F;

   // Loop filter selection encodings
   typedef enum logic [1:0] {
      FILTER_TC8      = 2'h0,
      FILTER_TC16     = 2'h1,
      FILTER_TC32     = 2'h2,
      FILTER_ADAPTIVE = 2'h3
   } loop_filter_select_t;

   // Recovery clock selection encodings
   typedef enum logic [1:0] {
      CLK_75_MHZ   = 2'h0,
      CLK_37P5_MHZ = 2'h1,
      CLK_18P75_MHZ = 2'h2,
      CLK_9P375_MHZ = 2'h3
   } recovery_clk_select_t;

   // Frequency in kHz of a recovery clock selection
   function automatic logic [16:0] clk_rate_khz(input logic [1:0] sel);
      case (sel)
         2'h0:    clk_rate_khz = CLK_RATE_75000_KHZ;
         2'h1:    clk_rate_khz = CLK_RATE_37500_KHZ;
         2'h2:    clk_rate_khz = CLK_RATE_18750_KHZ;
         default: clk_rate_khz = CLK_RATE_9375_KHZ;
      endcase
   endfunction : clk_rate_khz
endpackage : cdr_regs_pkg
`default_nettype wire

// *** logic/filter_cfg_if.sv ***
// Purpose : Carries loop filter configuration to the time constant selector
// Assumes : Single clock domain
// Notes   : ctrl side drives settings, sel side returns the time constant
`default_nettype none
interface filter_cfg_if;
   logic       enable;
   logic [1:0] filter_sel;
   logic       spacing_valid;
   logic [3:0] spacing;
   logic [5:0] time_const;

   modport ctrl (output enable, output filter_sel, output spacing_valid, output spacing, input time_const);
   modport sel  (input enable, input filter_sel, input spacing_valid, input spacing, output time_const);
endinterface : filter_cfg_if
`default_nettype wire

// *** logic/time_const_select.sv ***
// Purpose : Picks the recovery loop filter time constant
// Assumes : Spacing samples arrive as one-cycle valid strobes in bit times
// Notes   : Adaptive choice holds until a spacing in a known range arrives or a cleared enable returns it to 16
`default_nettype none
module time_const_select
   import cdr_regs_pkg::*;
(
   // Clock and reset
   input  wire logic   i_clk,
   input  wire logic   i_rst_n,
   // Configuration
   filter_cfg_if.sel   cfg
);
   logic [5:0] adapt_q;
   logic [5:0] adapt_d;

   // Adaptive constant from the latest falling-edge spacing
   always_comb begin
      adapt_d = adapt_q;
      if (!cfg.enable) begin
         adapt_d = TIME_CONST_16;
      end else if (cfg.spacing_valid) begin
         if (cfg.spacing >= SPACING_SHORT_MIN && cfg.spacing < SPACING_MID_MIN) begin
            adapt_d = TIME_CONST_32;                       // [RULE6]
         end else if (cfg.spacing >= SPACING_MID_MIN && cfg.spacing < SPACING_LONG_MIN) begin
            adapt_d = TIME_CONST_16;                       // [RULE6]
         end else if (cfg.spacing >= SPACING_LONG_MIN && cfg.spacing <= SPACING_LONG_MAX) begin
            adapt_d = TIME_CONST_8;                        // [RULE6]
         end
      end
   end

   // Adaptive constant register
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         adapt_q <= TIME_CONST_16;
      end else begin
         adapt_q <= adapt_d;
      end
   end

   // Fixed or adaptive selection
   always_comb begin
      case (loop_filter_select_t'(cfg.filter_sel))
         FILTER_TC8:      cfg.time_const = TIME_CONST_8;   // [RULE5]
         FILTER_TC16:     cfg.time_const = TIME_CONST_16;  // [RULE5]
         FILTER_TC32:     cfg.time_const = TIME_CONST_32;  // [RULE5]
         FILTER_ADAPTIVE: cfg.time_const = adapt_q;        // [RULE6]
         default:         cfg.time_const = TIME_CONST_16;
      endcase
   end
endmodule : time_const_select
`default_nettype wire

// *** testbench/cdr_regs_assertions.sv ***
// Purpose: Port checks of the recovery register bank
// Assumes: One clock, reset low at start
// Notes: Bound from the bench top file
`default_nettype none
module cdr_regs_assertions
   import cdr_regs_pkg::*;
(
   input wire logic        i_clk, i_rst_n, i_restart, i_reg_wr, i_reg_rd, i_cal_load,
   input wire logic [6:0]  i_reg_addr,
   input wire logic [15:0] i_reg_wdata, o_reg_rdata,
   input wire logic [7:0]  i_cal_high, i_cal_low,
   input wire logic        o_recovery_enable,
   input wire logic [1:0]  o_recovery_clk_sel,
   input wire logic [16:0] o_recovery_clk_khz,
   input wire logic [5:0]  o_time_const
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // Control write that the bank must accept
   logic ctl_wr;
   assign ctl_wr = i_reg_wr && i_reg_addr == RECOVERY_CONTROL_ADDR && !i_restart;
   sequence cal_taken; i_cal_load && !i_restart; endsequence
   sequence cal_read; i_reg_rd && i_reg_addr == OSC_CAL_STATUS_ADDR && !i_cal_load; endsequence
   a_cal_pack: assert property (cal_taken ##1 cal_read |=> o_reg_rdata == {$past(i_cal_high, 2), $past(i_cal_low, 2)})
      else $error("cal word not packed high then low");
   a_rsvd_zero: assert property (i_reg_rd && i_reg_addr == RECOVERY_CONTROL_ADDR |=> !(|(o_reg_rdata & ~RECOVERY_CONTROL_MASK)))
      else $error("reserved control bits read non-zero");
   a_ctl_write: assert property (ctl_wr |=> o_recovery_enable == $past(i_reg_wdata[0]) && o_recovery_clk_sel == $past(i_reg_wdata[6:5]))
      else $error("control write not applied");
   a_fixed_filter: assert property (ctl_wr && i_reg_wdata[3:2] != 2'h3 && i_reg_wdata[0] |=> o_time_const == (6'h08 << $past(i_reg_wdata[3:2])))
      else $error("fixed time constant wrong");
   a_off_zero: assert property (!o_recovery_enable |-> o_time_const == 6'h00)
      else $error("time constant while disabled");
   a_khz_decode: assert property (o_recovery_clk_khz == (CLK_RATE_75000_KHZ >> o_recovery_clk_sel))
      else $error("recovery clock rate wrong");
   a_restart_hold: assert property (i_restart |=> $stable(o_recovery_enable) && $stable(o_recovery_clk_sel))
      else $error("settings changed during restart");
   a_ro_write: assert property (i_reg_wr && i_reg_addr == OSC_CAL_STATUS_ADDR |=> $stable(o_recovery_clk_sel))
      else $error("status write disturbed control");
endmodule : cdr_regs_assertions
`default_nettype wire

// *** testbench/host_model.sv ***
// Purpose: Host side of the register port
// Assumes: One-cycle strobes, read answer one cycle later
// Notes: Tasks are called from the bench
`default_nettype none
module host_model (
   input  wire logic        i_clk,
   input  wire logic [15:0] i_reg_rdata,
   input  wire logic        i_reg_rvalid,
   output logic      [6:0]  o_reg_addr,
   output logic             o_reg_wr, o_reg_rd,
   output logic      [15:0] o_reg_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {o_reg_addr, o_reg_wr, o_reg_rd, o_reg_wdata} = '0;
   // Caller keeps clock selections legal for its baud rate
   task put_word(input logic [6:0] a, input logic [15:0] d);
      @(posedge i_clk);
      {o_reg_addr, o_reg_wdata, o_reg_wr} <= {a, d, 1'b1};
      @(posedge i_clk);
      {o_reg_wdata, o_reg_wr} <= {~d, 1'b0}; // Released data is inverted
   endtask : put_word
   // Read strobe; data taken with the valid flag
   task get_word(input logic [6:0] a, output logic [15:0] d);
      @(posedge i_clk);
      {o_reg_addr, o_reg_rd} <= {a, 1'b1};
      @(posedge i_clk);
      o_reg_rd <= 1'b0;
      // Answer stands until the next edge, taken there with its valid flag
      @(posedge i_clk);
      d = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 16'hXXXX;
   endtask : get_word
endmodule : host_model
`default_nettype wire

// *** testbench/wake_cdr_config_regs_bench.sv ***
// Purpose: Self-checking bench of the recovery register bank
// Assumes: 125 MHz clock, host model drives the register port
// Notes: Table rows write and read back the control word
`default_nettype none
module wake_cdr_config_regs_bench;
   import cdr_regs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 0, i_rst_n = 0, i_restart = 0, i_cal_load = 0, i_spacing_valid = 0;
   logic [7:0] i_cal_high = 0, i_cal_low = 0;
   logic [3:0] i_spacing = 0;
   logic [6:0] i_reg_addr;
   logic i_reg_wr, i_reg_rd, o_reg_rvalid, o_reg_hit, o_recovery_enable;
   logic [15:0] i_reg_wdata, o_reg_rdata, got;
   logic [1:0] o_recovery_clk_sel;
   logic [16:0] o_recovery_clk_khz;
   logic [5:0] o_time_const;
   int fails = 0, total_checks = 0;
   typedef struct packed {logic [15:0] wd, rb; logic en; logic [1:0] sel; logic [5:0] tc;} row_t;
   row_t rows [6] = '{'{16'h0065, 16'h0065, 1, 3, 6'h10}, '{16'hFFFF, 16'h006D, 1, 3, 6'h10},
      '{16'h0001, 16'h0001, 1, 0, 6'h08}, '{16'h0029, 16'h0029, 1, 1, 6'h20},
      '{16'h0048, 16'h0048, 0, 2, 6'h00}, '{16'h0012, 16'h0000, 0, 0, 6'h00}};
   // Spacing sample beside the time constant it should leave
   logic [9:0] adapt [8] = '{{4'h2, 6'h20}, {4'h9, 6'h08}, {4'h4, 6'h10}, {4'h3, 6'h20},
      {4'hA, 6'h08}, {4'h8, 6'h10}, {4'hB, 6'h10}, {4'h1, 6'h10}};
   always #4 i_clk = ~i_clk;
   wake_cdr_config_regs wake_cdr_config_regs_inst (.i_clk, .i_rst_n, .i_restart, .i_reg_addr, .i_reg_wr,
      .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .o_reg_hit, .i_cal_load, .i_cal_high, .i_cal_low,
      .i_spacing_valid, .i_spacing, .o_recovery_enable, .o_recovery_clk_sel, .o_recovery_clk_khz, .o_time_const);
   host_model host_model_inst (.i_clk, .i_reg_rdata(o_reg_rdata), .i_reg_rvalid(o_reg_rvalid),
      .o_reg_addr(i_reg_addr), .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd), .o_reg_wdata(i_reg_wdata));
   task automatic check(input string what, input logic [16:0] exp, seen);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic rd_chk(input string what, input logic [6:0] a, input logic [15:0] exp);
      host_model_inst.get_word(a, got);
      check(what, exp, got);
   endtask : rd_chk
   // Reset for n cycles, then the reset values
   task automatic reset_and_check(input int n);
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      repeat (n) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_clk);
      rd_chk("ctl", RECOVERY_CONTROL_ADDR, 16'h0004);
      rd_chk("cal", OSC_CAL_STATUS_ADDR, 16'h0000);
      check("tc_off", 6'h00, o_time_const);
   endtask : reset_and_check
   task report_and_stop;
      $display("Checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   initial begin
      reset_and_check(20);
      foreach (rows[k]) begin
         host_model_inst.put_word(RECOVERY_CONTROL_ADDR, rows[k].wd);
         rd_chk("ctl", RECOVERY_CONTROL_ADDR, rows[k].rb);
         check("enable", rows[k].en, o_recovery_enable);
         check("clk_sel", rows[k].sel, o_recovery_clk_sel);
         check("tc", rows[k].tc, o_time_const);
         check("hit_ctl", 1'b1, o_reg_hit);
      end
      // Calibration load read straight back, then a write that must not stick
      @(posedge i_clk);
      {i_cal_load, i_cal_high, i_cal_low} <= {1'b1, 8'hAB, 8'hCD};
      fork @(posedge i_clk) i_cal_load <= 1'b0; join_none
      rd_chk("cal", OSC_CAL_STATUS_ADDR, 16'hABCD);
      check("hit_cal", 1'b1, o_reg_hit);
      host_model_inst.put_word(OSC_CAL_STATUS_ADDR, 16'h1234);
      rd_chk("cal_ro", OSC_CAL_STATUS_ADDR, 16'hABCD);
      rd_chk("unmapped", 7'h10, 16'h0000);
      check("hit_none", 1'b0, o_reg_hit);
      // Restart keeps fields and refuses writes and loads
      host_model_inst.put_word(RECOVERY_CONTROL_ADDR, 16'h0065);
      @(posedge i_clk);
      {i_restart, i_cal_load, i_cal_high} <= {1'b1, 1'b1, 8'h11};
      host_model_inst.put_word(RECOVERY_CONTROL_ADDR, 16'h0000);
      {i_restart, i_cal_load} <= 2'b00;
      rd_chk("ctl_restart", RECOVERY_CONTROL_ADDR, 16'h0065);
      rd_chk("cal_restart", OSC_CAL_STATUS_ADDR, 16'hABCD);
      // Adaptive filter driven by edge spacing samples
      host_model_inst.put_word(RECOVERY_CONTROL_ADDR, 16'h000F);
      foreach (adapt[k]) begin
         @(posedge i_clk);
         {i_spacing_valid, i_spacing} <= {1'b1, adapt[k][9:6]};
         @(posedge i_clk);
         i_spacing_valid <= 1'b0;
         #1 check("adaptive", adapt[k][5:0], o_time_const);
      end
      reset_and_check(2);
      report_and_stop;
   end
   // Watchdog against a hang
   initial begin
      #20000;
      fails++;
      report_and_stop;
   end
endmodule : wake_cdr_config_regs_bench
bind wake_cdr_config_regs cdr_regs_assertions cdr_regs_assertions_inst (.i_clk, .i_rst_n, .i_restart, .i_reg_wr,
   .i_reg_rd, .i_cal_load, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_cal_high, .i_cal_low, .o_recovery_enable,
   .o_recovery_clk_sel, .o_recovery_clk_khz, .o_time_const);
`default_nettype wire
